// [common/css_pkg.sv]
package css_pkg;

  // Core clock rate and the cycles in one microsecond
  localparam int CLK_HZ     = 25_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  // Short-circuit check window on the mid rail
  localparam int T_WINDOW_US = 100;
  localparam int WINDOW_CYC  = T_WINDOW_US * CYC_PER_US;

  // Delay from step-up soft-start to inverter soft-start
  localparam int T_STAGGER_MS = 2;
  localparam int STAGGER_CYC  = T_STAGGER_MS * 1000 * CYC_PER_US;

  // Time from enable to both outputs in regulation
  localparam int T_REG_MS = 6;
  localparam int REG_CYC  = T_REG_MS * 1000 * CYC_PER_US;

  // Interval counter width, wide enough for the longest interval
  localparam int TMR_W = 18;

  // Synchronised comparator and pin inputs
  localparam int SYNC_W = 8;

  // Values after reset
  localparam logic LOCKOUT_RST = 1'b1;
  localparam logic HOT_RST     = 1'b0;

  // Sequencer states
  typedef enum logic [2:0] {
    SQ_OFF   = 3'h0,
    SQ_CHECK = 3'h1,
    SQ_BOOST = 3'h2,
    SQ_INV   = 3'h3,
    SQ_FAULT = 3'h4,
    SQ_HALT  = 3'h5,
    SQ_DRAIN = 3'h6
  } css_state_e;

endpackage : css_pkg

// [design/css_sync.sv]
`timescale 1ns/10ps
module css_sync
  import css_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             core_clk,  // Core clock
  input  wire logic             rst_b,     // Async reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // Inputs from another domain
  output logic      [WIDTH-1:0] sync_out   // Synchronised copies
);

  logic [WIDTH-1:0] stage1;

  // Two-flop chain; only the second flop reads the first
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : css_sync

// [design/css_timer.sv]
`timescale 1ns/10ps
module css_timer
  import css_pkg::*;
(
  input  wire logic             core_clk,  // Core clock
  input  wire logic             rst_b,     // Async reset, active low
  input  wire logic             load,      // Restart the interval
  input  wire logic [TMR_W-1:0] load_val,  // Cycles minus one
  output logic                  done       // Interval has elapsed
);

  logic [TMR_W-1:0] cnt;

  // Down counter that parks at zero
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt <= '0;
    else if (load)
      cnt <= load_val;
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  assign done = (cnt == '0);

endmodule : css_timer

// [design/css_seq.sv]
`timescale 1ns/10ps
// Summary of operation
// - Converters run only while the enable input is high.
// - Enable low stops switching and powers down internal blocks.
// - In shutdown every power switch is held open.
// - Enable rising closes the boost rectifier for a fixed 100 us window.
// - Mid rail still low after the window: rectifier off until new enable.
// - Start on enable rising or on supply becoming valid with enable high.
// - First phase precharges the mid rail with the rectifier current-limited.
// - Mid rail at input: rectifier fully on, then step-up soft-start.
// - Inverter soft-start begins about 2 ms after step-up soft-start.
// - Both outputs are in regulation about 6 ms after enable.
// - Input lockout holds the device in shutdown whatever enable does.
// - Lockout uses separate entry and exit thresholds for hysteresis.
// - Junction above the trip temperature stops operation.
// - Operation resumes once the junction falls below the resume point.
// - Enable falling enters shutdown and halts both switch nodes.
// - After switching halts, both discharge switches close.
// - Both outputs at zero volts opens the discharge switches.
module css_seq
  import css_pkg::*;
#(
  parameter int STAGGER_CYCLES = STAGGER_CYC,  // Step-up to inverter delay
  parameter int REG_CYCLES     = REG_CYC       // Enable to regulation
)
(
  input  wire logic core_clk,                    // Core clock, 25 MHz
  input  wire logic rst_b,                       // Power-on reset, low
  input  wire logic enable,                      // Enable pin from host
  input  wire logic mid_rail_ge_input,           // Mid rail reached input
  input  wire logic input_below_entry,           // Input under entry level
  input  wire logic input_above_exit,            // Input over exit level
  input  wire logic temp_above_trip,             // Junction over trip
  input  wire logic temp_below_resume,           // Junction under resume
  input  wire logic mid_rail_at_zero,            // Mid rail discharged
  input  wire logic negative_output_at_zero,     // Negative rail discharged
  output logic      bias_on,                     // Internal blocks powered
  output logic      boost_rectifier_switch_on,   // Rectifier closed
  output logic      boost_rectifier_ilimit,      // Rectifier current-limited
  output logic      boost_switch_node_en,        // Step-up switching
  output logic      boost_soft_start,            // Step-up soft-start
  output logic      inverter_switch_node_en,     // Inverter switching
  output logic      inverter_soft_start,         // Inverter soft-start
  output logic      mid_rail_discharge_on,       // Mid rail to input switch
  output logic      negative_output_discharge_on, // Negative rail to ground
  output logic      in_regulation,               // Both outputs regulated
  output logic      short_fault                  // Mid rail short found
);

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic              en_s;
  logic              mid_ok;
  logic              below_entry;
  logic              above_exit;
  logic              over_trip;
  logic              under_resume;
  logic              mid_zero;
  logic              neg_zero;
  logic              lockout;
  logic              hot;
  logic              run_ok;
  css_state_e        state;
  css_state_e        next_state;
  logic              ph_load;
  logic [TMR_W-1:0]  ph_val;
  logic              ph_done;
  logic              reg_load;
  logic              reg_done;

  // Every pin and comparator passes two flops before use
  assign raw_in = {enable, mid_rail_ge_input, input_below_entry,
                   input_above_exit, temp_above_trip, temp_below_resume,
                   mid_rail_at_zero, negative_output_at_zero};

  css_sync #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign en_s         = sync_in[7];
  assign mid_ok       = sync_in[6];
  assign below_entry  = sync_in[5];
  assign above_exit   = sync_in[4];
  assign over_trip    = sync_in[3];
  assign under_resume = sync_in[2];
  assign mid_zero     = sync_in[1];
  assign neg_zero     = sync_in[0];

  // Lockout latch; separate set and clear levels give the hysteresis
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      lockout <= LOCKOUT_RST;
    else if (below_entry)
      lockout <= 1'b1;
    else if (above_exit)
      lockout <= 1'b0;
  end

  // Thermal latch; trip wins if both comparators glitch together
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      hot <= HOT_RST;
    else if (over_trip)
      hot <= 1'b1;
    else if (under_resume)
      hot <= 1'b0;
  end

  // Conditions under which the converters may run
  assign run_ok = en_s && !lockout && !hot;

  // Phase timer: check window, then step-up to inverter delay
  css_timer u_phase (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .load     (ph_load),
    .load_val (ph_val),
    .done     (ph_done)
  );

  // Time since the sequence started, for the regulation flag
  css_timer u_since (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .load     (reg_load),
    .load_val (TMR_W'(REG_CYCLES - 1)),
    .done     (reg_done)
  );

  // Timers reload on the way into the state they time
  always_comb
  begin
    ph_load  = 1'b0;
    ph_val   = TMR_W'(WINDOW_CYC - 1);
    reg_load = 1'b0;
    if (state == SQ_OFF && next_state == SQ_CHECK)
    begin
      ph_load  = 1'b1;
      reg_load = 1'b1;
    end
    else if (state == SQ_CHECK && next_state == SQ_BOOST)
    begin
      ph_load = 1'b1;
      ph_val  = TMR_W'(STAGGER_CYCLES - 1);
    end
  end

  // Sequencer; an abort always halts switching before draining
  always_comb
  begin
    next_state = state;
    unique case (state)
      SQ_OFF:
        if (run_ok)
          next_state = SQ_CHECK;
      SQ_CHECK:
        if (!run_ok)
          next_state = SQ_HALT;
        else if (ph_done)
          next_state = mid_ok ? SQ_BOOST : SQ_FAULT;
      SQ_BOOST:
        if (!run_ok)
          next_state = SQ_HALT;
        else if (ph_done)
          next_state = SQ_INV;
      SQ_INV:
        if (!run_ok)
          next_state = SQ_HALT;
      SQ_FAULT:
        if (!run_ok)
          next_state = SQ_HALT;
      SQ_HALT:
        next_state = SQ_DRAIN;
      SQ_DRAIN:
        if (mid_zero && neg_zero)
          next_state = SQ_OFF;
      default:
        next_state = SQ_HALT;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= SQ_OFF;
    else
      state <= next_state;
  end

  // Outputs decoded from the next state so each is a flop
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bias_on                      <= 1'b0;
      boost_rectifier_switch_on    <= 1'b0;
      boost_rectifier_ilimit       <= 1'b0;
      boost_switch_node_en         <= 1'b0;
      boost_soft_start             <= 1'b0;
      inverter_switch_node_en      <= 1'b0;
      inverter_soft_start          <= 1'b0;
      mid_rail_discharge_on        <= 1'b0;
      negative_output_discharge_on <= 1'b0;
      in_regulation                <= 1'b0;
      short_fault                  <= 1'b0;
    end
    else
    begin
      // Bias stays up while draining, the switches need drive
      bias_on <= (next_state != SQ_OFF);
      boost_rectifier_switch_on <= next_state inside
        {SQ_CHECK, SQ_BOOST, SQ_INV};
      // Limit drops as soon as the mid rail catches up
      boost_rectifier_ilimit <= (next_state == SQ_CHECK) && !mid_ok;
      boost_switch_node_en <= next_state inside
        {SQ_BOOST, SQ_INV};
      boost_soft_start <= (next_state == SQ_BOOST);
      inverter_switch_node_en <= (next_state == SQ_INV);
      inverter_soft_start <= (next_state == SQ_INV) && !reg_done;
      mid_rail_discharge_on <= (next_state == SQ_DRAIN);
      negative_output_discharge_on <= (next_state == SQ_DRAIN);
      in_regulation <= (next_state == SQ_INV) && reg_done;
      short_fault <= (next_state == SQ_FAULT);
    end
  end

  // Helper counters read only by the checks below
  logic [TMR_W-1:0] win_cnt;
  logic [TMR_W-1:0] stag_cnt;
  logic [TMR_W-1:0] since_cnt;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      win_cnt   <= '0;
      stag_cnt  <= '0;
      since_cnt <= '0;
    end
    else
    begin
      win_cnt   <= (next_state == SQ_CHECK && state == SQ_CHECK) ?
                   win_cnt + 1'b1 : '0;
      stag_cnt  <= (next_state == SQ_BOOST && state == SQ_BOOST) ?
                   stag_cnt + 1'b1 : '0;
      if (next_state == SQ_OFF || state == SQ_OFF)
        since_cnt <= '0;
      else if (since_cnt != '1)
        since_cnt <= since_cnt + 1'b1;
    end
  end

  a_shutdown_open: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_OFF && !run_ok) |=> !boost_rectifier_switch_on &&
      !boost_switch_node_en && !inverter_switch_node_en && !bias_on)
    else $error("switch closed in shutdown");

  a_run_needs_en: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    boost_switch_node_en |-> $past(en_s))
    else $error("step-up switching without enable");

  a_window_len: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_CHECK && run_ok && next_state != SQ_CHECK) |->
      win_cnt == TMR_W'(WINDOW_CYC - 1))
    else $error("check window has wrong length");

  a_short_latch: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_CHECK && ph_done && !mid_ok && run_ok) |=>
      short_fault && !boost_rectifier_switch_on)
    else $error("rectifier left on after failed check");

  a_fault_holds: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_FAULT && run_ok) |=> state == SQ_FAULT
      ##1 !boost_rectifier_switch_on)
    else $error("fault released without enable pulse");

  a_precharge_lim: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_CHECK && next_state == SQ_CHECK && !mid_ok) |=>
      boost_rectifier_ilimit && boost_rectifier_switch_on)
    else $error("precharge not current-limited");

  a_boost_after_full: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $rose(boost_soft_start) |-> boost_rectifier_switch_on &&
      !boost_rectifier_ilimit && $past(mid_ok))
    else $error("step-up started before rectifier fully on");

  a_inv_stagger: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_BOOST && next_state == SQ_INV) |->
      stag_cnt == TMR_W'(STAGGER_CYCLES - 1))
    else $error("inverter soft-start stagger wrong");

  a_reg_time: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $rose(in_regulation) |-> since_cnt >= TMR_W'(REG_CYCLES))
    else $error("regulation flagged too early");

  a_reg_prompt: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_INV && reg_done && run_ok) |=> in_regulation)
    else $error("regulation flag late");

  a_abort_halt: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!run_ok && state inside {SQ_CHECK, SQ_BOOST, SQ_INV, SQ_FAULT})
      |=> state == SQ_HALT && !boost_switch_node_en &&
      !inverter_switch_node_en)
    else $error("start-up not aborted");

  a_lockout_hyst: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (lockout && !above_exit) |=> lockout)
    else $error("lockout released below exit level");

  a_thermal_hyst: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (hot && under_resume && !over_trip) |=> !hot)
    else $error("thermal stop not released");

  a_drain_after_halt: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    state == SQ_HALT |=> mid_rail_discharge_on &&
      negative_output_discharge_on && !boost_switch_node_en)
    else $error("discharge not applied after halt");

  a_drain_ends: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SQ_DRAIN && mid_zero && neg_zero) |=>
      !mid_rail_discharge_on && !negative_output_discharge_on)
    else $error("discharge switches left closed");

  c_regulated: cover property (
    @(posedge core_clk) disable iff (!rst_b) $rose(in_regulation));

  c_short: cover property (
    @(posedge core_clk) disable iff (!rst_b) $rose(short_fault));

  c_thermal_abort: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    (hot && state == SQ_INV) ##1 state == SQ_HALT);

  c_drained: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    state == SQ_DRAIN ##1 state == SQ_OFF);

endmodule : css_seq

// [sim/css_host.sv]
`timescale 1ns/10ps
// Host controller model that owns the enable pin
module css_host
(
  input  wire logic       core_clk,  // Core clock
  input  wire logic       want_on,   // Level the host aims for
  input  wire logic [3:0] lag,       // Cycles before the pin follows
  output logic            enable     // Enable pin to the device
);
  logic [3:0] cnt;

  initial
  begin
    enable = 1'h0;
    cnt    = 4'h0;
  end

  // Pin follows the request late, so prompt and slow hosts both occur
  always @(negedge core_clk)
  begin
    if (want_on == enable)
      cnt <= 4'h0;
    else if (cnt >= lag)
      enable <= want_on;
    else
      cnt <= cnt + 4'h1;
  end
endmodule : css_host

// [sim/converter_startup_sequencer_bench.sv]
`timescale 1ns/10ps
module converter_startup_sequencer_bench;
  import css_pkg::*;
  localparam int STG = 40;    // Shortened step-up to inverter delay
  localparam int REG = 2600;  // Shortened time to regulation
  localparam int CHK = 2500;  // Rectifier check window in cycles

  logic        core_clk    = 1'h0;
  logic        rst_b       = 1'h0;
  logic        want_on     = 1'h0;
  logic [3:0]  lag         = 4'h0;
  logic        mid_ge      = 1'h0;
  logic        below_entry = 1'h0;
  logic        above_exit  = 1'h0;
  logic        hot         = 1'h0;
  logic        cool        = 1'h1;
  logic        mid_zero    = 1'h1;
  logic        neg_zero    = 1'h1;
  logic [15:0] rnd         = 16'hDF53;
  logic        enable;
  wire  [10:0] dv;
  int          err_total   = 0;
  int          tests_run   = 0;
  int          cyc         = 0;

  // 40 ns clock
  always #20 core_clk = ~core_clk;

  css_host i_css_host (
    .core_clk (core_clk),
    .want_on  (want_on),
    .lag      (lag),
    .enable   (enable)
  );

  css_seq #(.STAGGER_CYCLES(STG), .REG_CYCLES(REG)) i_css_seq (
    .core_clk                     (core_clk),
    .rst_b                        (rst_b),
    .enable                       (enable),
    .mid_rail_ge_input            (mid_ge),
    .input_below_entry            (below_entry),
    .input_above_exit             (above_exit),
    .temp_above_trip              (hot),
    .temp_below_resume            (cool),
    .mid_rail_at_zero             (mid_zero),
    .negative_output_at_zero      (neg_zero),
    .bias_on                      (dv[10]),
    .boost_rectifier_switch_on    (dv[9]),
    .boost_rectifier_ilimit       (dv[8]),
    .boost_switch_node_en         (dv[7]),
    .boost_soft_start             (dv[6]),
    .inverter_switch_node_en      (dv[5]),
    .inverter_soft_start          (dv[4]),
    .mid_rail_discharge_on        (dv[3]),
    .negative_output_discharge_on (dv[2]),
    .in_regulation                (dv[1]),
    .short_fault                  (dv[0])
  );

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  // Reference model: expected output vector for each sequencer state
  function automatic logic [10:0] ev(input css_state_e s, input logic il,
                                     input logic rg);
    case (s)
      SQ_CHECK: ev = {2'h3, il, 8'h00};
      SQ_BOOST: ev = 11'h6C0;
      SQ_INV:   ev = {4'hD, 1'h0, 1'h1, ~rg, 2'h0, rg, 1'h0};
      SQ_FAULT: ev = 11'h401;
      SQ_HALT:  ev = 11'h400;
      SQ_DRAIN: ev = 11'h40C;
      default:  ev = 11'h000;
    endcase
  endfunction : ev

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Bounded wait for an output vector, then compare; n counts edges
  task automatic wait_vec(input string what, input logic [10:0] exp,
                          input int lim, output int n);
    n = 0;
    while (dv !== exp && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(what, {5'h00, dv}, {5'h00, exp});
  endtask : wait_vec

  // Enable high, then follow the sequence only if full, else return at check entry; short keeps the mid rail low
  task automatic start_up(input logic full, input logic short_mid);
    int n;
    int t;
    rnd = lfsr(rnd);
    mid_zero <= 1'h0;
    neg_zero <= 1'h0;
    mid_ge <= 1'h0;
    lag <= rnd[3:0];
    want_on <= 1'h1;
    wait_vec("check entry", ev(SQ_CHECK, 1'h1, 1'h0), 40, n);
    if (full && short_mid)
    begin
      wait_vec("short fault", ev(SQ_FAULT, 1'h0, 1'h0), CHK + 8, n);
      chk("fault time", n[15:0], CHK[15:0]);
    end
    else if (full)
    begin
      t = 100 + int'(rnd[9:0]);
      repeat (t) @(negedge core_clk);
      mid_ge <= 1'h1;
      wait_vec("rectifier full", ev(SQ_CHECK, 1'h0, 1'h0), 8, n);
      t += n;
      wait_vec("step-up start", ev(SQ_BOOST, 1'h0, 1'h0), CHK, n);
      t += n;
      chk("check window", t[15:0], CHK[15:0]);
      wait_vec("inverter start", ev(SQ_INV, 1'h0, 1'h0), STG + 4, n);
      chk("stagger", n[15:0], STG[15:0]);
      t += n;
      wait_vec("regulation", ev(SQ_INV, 1'h0, 1'h1), 200, n);
      t += n;
      chk("regulation time", {15'h0000, t >= REG && t <= REG + 1},
          16'h0001);
    end
  endtask : start_up

  // Halt, discharge with both switches, open them once both rails are low
  // Halt bound covers the slowest host lag plus the two sync flops
  task automatic drain(input string what);
    int n;
    mid_ge <= 1'h0;
    wait_vec({what, " halt"}, ev(SQ_HALT, 1'h0, 1'h0), 24, n);
    wait_vec({what, " drain"}, ev(SQ_DRAIN, 1'h0, 1'h0), 2, n);
    mid_zero <= 1'h1;
    repeat (6) @(negedge core_clk);
    chk({what, " one rail low"}, {5'h00, dv}, 16'h040C);
    neg_zero <= 1'h1;
    wait_vec({what, " off"}, ev(SQ_OFF, 1'h0, 1'h0), 8, n);
  endtask : drain

  // Hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      final_report();
    end
  end

  initial
  begin
    repeat (8) @(negedge core_clk);
    rst_b <= 1'h1;
    @(negedge core_clk);
    chk("reset outputs", {5'h00, dv}, 16'h0000);
    // Locked after reset: enable alone must not start anything
    want_on <= 1'h1;
    repeat (30) @(negedge core_clk);
    chk("locked start", {5'h00, dv}, 16'h0000);
    // Supply becomes valid while enable is already high
    above_exit <= 1'h1;
    start_up(1'h1, 1'h0);
    want_on <= 1'h0;
    drain("stop");
    // Enable dropped inside the check window
    start_up(1'h0, 1'h0);
    want_on <= 1'h0;
    drain("check abort");
    // Shorted mid rail, held fault, then a fresh enable pulse
    start_up(1'h1, 1'h1);
    repeat (100) @(negedge core_clk);
    chk("fault held", {5'h00, dv}, 16'h0401);
    want_on <= 1'h0;
    drain("fault");
    start_up(1'h0, 1'h0);
    // Input lockout in mid start-up, then hysteresis on release
    below_entry <= 1'h1;
    above_exit <= 1'h0;
    drain("lockout");
    below_entry <= 1'h0;
    repeat (30) @(negedge core_clk);
    chk("between levels", {5'h00, dv}, 16'h0000);
    above_exit <= 1'h1;
    start_up(1'h1, 1'h0);
    // Overheat in regulation, then resume only below the lower point
    hot <= 1'h1;
    cool <= 1'h0;
    drain("overheat");
    hot <= 1'h0;
    repeat (30) @(negedge core_clk);
    chk("still warm", {5'h00, dv}, 16'h0000);
    cool <= 1'h1;
    start_up(1'h0, 1'h0);
    want_on <= 1'h0;
    drain("last stop");
    final_report();
  end
endmodule : converter_startup_sequencer_bench
